// ==== design/debug_trig_pkg.sv ====
// Constants and types shared by the debug trigger and trace control block
package debug_trig_pkg;

	// Register offsets on the plain register port
	localparam logic [1:0] ADDR_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_FIFO = 2'h2;

	// Trace store geometry
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W = 4;
	localparam int DATA_W = 8;

	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// Status register field positions
	localparam int ST_AF_POS = 7;
	localparam int ST_BF_POS = 6;
	localparam int ST_RUN_ACTIVE_FLAG_POS = 5;
	localparam int ST_RSVD_POS = 4;
	localparam int ST_CNT_MSB = 3;

	// Trace mode latched at arming
	localparam logic TRACE_END = 1'b0;
	localparam logic TRACE_BEGIN = 1'b1;

	// Control register layout, bit 7 first
	typedef struct packed {
		logic module_enable;
		logic arm;
		logic tag_select;
		logic break_request_enable;
		logic cmp_a_dir_value;
		logic cmp_a_dir_qualify;
		logic cmp_b_dir_value;
		logic cmp_b_dir_qualify;
	} debug_control_s;

	// One observed CPU bus cycle with its comparator hits
	typedef struct packed {
		logic valid;
		logic is_read;
		logic cmp_a_hit;
		logic cmp_b_hit;
		logic [DATA_W-1:0] word;
	} bus_mon_s;

	// Run sequencer, Gray coded along idle, pre, post
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PRE = 2'b01,
		ST_POST = 2'b11
	} run_state_e;

endpackage

// ==== design/debug_trigger_trace_control.sv ====
// Debug trigger, trace store and break request control
//
// Function
// - Control register accessible at all times
// - Bit 7 enables module; blocked while secured
// - Arm write sets arm, flag; run clears
// - Writing arm or enable zero ends run
// - Bit 5 picks tag or force break
// - Bit 4 lets triggers request CPU break
// - End trace breaks on qualified trigger
// - Begin trace breaks when FIFO fills
// - Break timing set only by trace mode
// - Bits 3:2 qualify comparator A direction
// - Bits 1:0 qualify comparator B direction
// - Status bit 7 records A match
// - Status bit 6 records B match
// - Status bit 5 mirrors arm while enabled
// - Run ends on full or trigger
// - Count cleared at start, holds words
// - Count does not drop on reads
// - Status register ignores all writes
`timescale 1ns/1ns
`default_nettype none

module debug_trigger_trace_control
	import debug_trig_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output var logic [7:0] reg_rdata,
	input wire logic mcu_secure,
	input wire logic begin_trace,
	input wire bus_mon_s bus_mon,
	output var logic break_req,
	output var logic break_tag,
	output var logic run_armed
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEPTH - 1);

	// Direction qualifier shared by both comparators
	function automatic logic dir_ok(
		input logic hit,
		input logic is_read,
		input logic dir_value,
		input logic dir_qualify
	);
		dir_ok = hit & (~dir_qualify | (is_read == dir_value));
	endfunction

	// Reset synchroniser
	// Clear is immediate; release waits two edges so no flop sees a runt
	logic rst_meta_q;
	logic rst_sync_q;
	wire logic rst_n;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign rst_n = rst_sync_q;

	// State registers
	debug_control_s ctrl_q;
	debug_control_s ctrl_d;
	run_state_e state_q;
	run_state_e state_d;
	logic mode_q;
	logic mode_d;
	logic af_q;
	logic af_d;
	logic bf_q;
	logic bf_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [PTR_W-1:0] wptr_q;
	logic [PTR_W-1:0] wptr_d;
	logic [PTR_W-1:0] rptr_q;
	logic [PTR_W-1:0] rptr_d;
	logic [DATA_W-1:0] mem_q [DEPTH];
	logic brk_q;
	logic tag_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// Register port decode
	wire logic wr_ctrl;
	wire logic rd_status;
	wire logic rd_ctrl;
	wire logic rd_fifo;
	wire debug_control_s wctl;

	assign wr_ctrl = reg_wr & (reg_addr == ADDR_CONTROL);
	assign rd_ctrl = reg_rd & (reg_addr == ADDR_CONTROL);
	assign rd_status = reg_rd & (reg_addr == ADDR_STATUS);
	assign rd_fifo = reg_rd & (reg_addr == ADDR_FIFO);
	assign wctl = debug_control_s'(reg_wdata);

	// Enable and arm requests from a control write
	wire logic en_next;
	wire logic start_run;
	wire logic stop_run;

	assign en_next = wr_ctrl ? (wctl.module_enable & ~mcu_secure) : ctrl_q.module_enable;
	assign start_run = wr_ctrl & wctl.arm & en_next & ~ctrl_q.arm;
	assign stop_run = wr_ctrl & ctrl_q.arm & (~wctl.arm | ~en_next);

	// Comparator qualification, only counted while armed
	// Hits outside a run are ignored so the flags cover this run only
	wire logic armed;
	wire logic hit_a;
	wire logic hit_b;
	wire logic trigger;

	assign armed = (state_q != ST_IDLE);
	assign hit_a = armed & bus_mon.valid & dir_ok(bus_mon.cmp_a_hit, bus_mon.is_read,
		ctrl_q.cmp_a_dir_value, ctrl_q.cmp_a_dir_qualify);
	assign hit_b = armed & bus_mon.valid & dir_ok(bus_mon.cmp_b_hit, bus_mon.is_read,
		ctrl_q.cmp_b_dir_value, ctrl_q.cmp_b_dir_qualify);
	assign trigger = hit_a | hit_b;

	// Which bus cycles are written into the trace store
	wire logic store;
	wire logic in_pre;
	wire logic in_post;

	assign in_pre = (state_q == ST_PRE);
	assign in_post = (state_q == ST_POST);
	assign store = bus_mon.valid & ((in_pre & ((mode_q == TRACE_END) | trigger)) | in_post);

	// Run completion: full in begin trace, trigger in end trace
	// A manual stop in the same cycle wins, so no break is raised
	wire logic fill_done;
	wire logic trig_done;
	wire logic run_done;

	assign fill_done = store & (mode_q == TRACE_BEGIN) & (cnt_q == CNT_LAST);
	assign trig_done = in_pre & trigger & (mode_q == TRACE_END);
	assign run_done = (fill_done | trig_done) & ~stop_run;

	// Break requests follow completion, trace mode only decides when
	wire logic brk_fire;

	assign brk_fire = run_done & ctrl_q.break_request_enable;

	// Sequencer next state
	// Trace mode is latched at arming so a later level change is ignored
	always_comb begin
		state_d = state_q;
		mode_d = mode_q;
		case (state_q)
			ST_IDLE: begin
				if (start_run) begin
					state_d = ST_PRE;
					mode_d = begin_trace;
				end
			end
			ST_PRE: begin
				if (stop_run | trig_done) begin
					state_d = ST_IDLE;
				end else if (trigger & (mode_q == TRACE_BEGIN)) begin
					state_d = fill_done ? ST_IDLE : ST_POST;
				end
			end
			ST_POST: begin
				if (stop_run | fill_done) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Control register next value
	// Enable cannot be set while secured; clearing it is always allowed
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d.tag_select = wctl.tag_select;
			ctrl_d.break_request_enable = wctl.break_request_enable;
			ctrl_d.cmp_a_dir_value = wctl.cmp_a_dir_value;
			ctrl_d.cmp_a_dir_qualify = wctl.cmp_a_dir_qualify;
			ctrl_d.cmp_b_dir_value = wctl.cmp_b_dir_value;
			ctrl_d.cmp_b_dir_qualify = wctl.cmp_b_dir_qualify;
		end
		ctrl_d.module_enable = en_next;
		if (start_run) begin
			ctrl_d.arm = 1'b1;
		end else if (stop_run | run_done) begin
			ctrl_d.arm = 1'b0;
		end
	end

	// Match flags: cleared at arming, sticky until the next run
	always_comb begin
		af_d = af_q;
		bf_d = bf_q;
		if (start_run) begin
			af_d = 1'b0;
			bf_d = 1'b0;
		end
		if (hit_a) begin
			af_d = 1'b1;
		end
		if (hit_b) begin
			bf_d = 1'b1;
		end
	end

	// Write pointer and valid word count, saturating at the depth
	// The count stops at the depth while the pointer keeps wrapping
	wire logic [PTR_W-1:0] wptr_inc;
	wire logic [CNT_W-1:0] cnt_inc;

	assign wptr_inc = PTR_W'(wptr_q + 1'b1);
	assign cnt_inc = (cnt_q == CNT_FULL) ? cnt_q : CNT_W'(cnt_q + 1'b1);

	always_comb begin
		wptr_d = wptr_q;
		cnt_d = cnt_q;
		if (start_run) begin
			wptr_d = '0;
			cnt_d = '0;
		end else if (store) begin
			wptr_d = wptr_inc;
			cnt_d = cnt_inc;
		end
	end

	// Oldest slot once the store has wrapped, counting this cycle's store
	wire logic wrapped;
	wire logic [PTR_W-1:0] oldest;

	assign wrapped = (cnt_d == CNT_FULL);
	assign oldest = store ? wptr_inc : wptr_q;

	// Read pointer: oldest word after a wrapped run, else slot zero
	always_comb begin
		rptr_d = rptr_q;
		if (start_run) begin
			rptr_d = '0;
		end else if ((run_done | stop_run) & wrapped) begin
			rptr_d = oldest;
		end else if (rd_fifo) begin
			rptr_d = PTR_W'(rptr_q + 1'b1);
		end
	end

	// Status image; bit 4 is held at zero
	// Count stays live during a run and holds after it ends
	logic [7:0] status_word;

	always_comb begin
		status_word = 8'h00;
		status_word[ST_AF_POS] = af_q;
		status_word[ST_BF_POS] = bf_q;
		status_word[ST_RUN_ACTIVE_FLAG_POS] = ctrl_q.arm & ctrl_q.module_enable;
		status_word[ST_RSVD_POS] = 1'b0;
		status_word[ST_CNT_MSB:0] = cnt_q;
	end

	// Read data selection, unmapped offsets answer zero
	always_comb begin
		rdata_d = READ_IDLE;
		if (rd_ctrl) begin
			rdata_d = ctrl_q;
		end else if (rd_status) begin
			rdata_d = status_word;
		end else if (rd_fifo) begin
			rdata_d = mem_q[rptr_q];
		end
	end

	// Control and sequencer flip-flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= debug_control_s'(CONTROL_RESET);
			state_q <= ST_IDLE;
			mode_q <= TRACE_END;
		end else begin
			ctrl_q <= ctrl_d;
			state_q <= state_d;
			mode_q <= mode_d;
		end
	end

	// Status flags and count; no write path reaches them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			af_q <= 1'b0;
			bf_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			af_q <= af_d;
			bf_q <= bf_d;
			cnt_q <= cnt_d;
		end
	end

	// Trace store pointers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
		end
	end

	// Trace store words, one writer per slot
	// Each slot has its own process so every word has a single driver
	for (genvar g = 0; g < DEPTH; g++) begin : gen_slot
		wire logic slot_we;

		assign slot_we = store & (wptr_q == PTR_W'(g));

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				mem_q[g] <= '0;
			end else if (slot_we) begin
				mem_q[g] <= bus_mon.word;
			end
		end
	end

	// Break request pulse with its type
	// The type bit is low whenever no request stands
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			brk_q <= 1'b0;
			tag_q <= 1'b0;
		end else begin
			brk_q <= brk_fire;
			tag_q <= brk_fire & ctrl_q.tag_select;
		end
	end

	// Read data register, valid only in the cycle after the strobe
	// Software must take the word in that cycle; it reads zero after
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= READ_IDLE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = rdata_q;
	assign break_req = brk_q;
	assign break_tag = tag_q;
	assign run_armed = ctrl_q.arm;

endmodule

`default_nettype wire

// ==== tb/cpu_bus_model.sv ====
// CPU bus stand-in feeding monitored bus cycles to the block
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model import debug_trig_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire bus_mon_s req,
	output var bus_mon_s bus_mon
);
	logic [7:0] last_q;
	// Idle cycles show the previous word inverted, so every second one repeats the last real word
	assign bus_mon = req.valid ? req : {4'h0, ~last_q};
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			last_q <= 8'h00;
		end else begin
			last_q <= bus_mon.word;
		end
	end
endmodule
`default_nettype wire

// ==== tb/debug_trig_asserts.sv ====
// Port checker for the debug trigger and trace control block
`timescale 1ns/1ns
`default_nettype none
module debug_trig_asserts import debug_trig_pkg::*; #(parameter int DEPTH = FIFO_DEPTH) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic mcu_secure,
	input wire logic begin_trace,
	input wire bus_mon_s bus_mon,
	input wire logic break_req,
	input wire logic break_tag,
	input wire logic run_armed
);
	logic [7:0] ctl_q;
	logic mode_q;
	// Qualified comparator hits against the shadowed control bits
	wire logic cw = reg_wr && reg_addr == ADDR_CONTROL;
	wire logic hit_a = bus_mon.cmp_a_hit && (!ctl_q[2] || bus_mon.is_read == ctl_q[3]);
	wire logic hit_b = bus_mon.cmp_b_hit && (!ctl_q[0] || bus_mon.is_read == ctl_q[1]);
	wire logic trg = run_armed && bus_mon.valid && (hit_a || hit_b);
	// Shadow of control writes; trace mode frozen while armed
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_q <= 8'h00;
			mode_q <= 1'h0;
		end else begin
			if (cw) ctl_q <= reg_wdata;
			if (!run_armed) mode_q <= begin_trace;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_arm; cw && reg_wdata[7:6] == 2'h3 && !mcu_secure; endsequence
	sequence s_end; trg && !mode_q && !cw; endsequence
	a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == READ_IDLE)
		else $error("read data outside read cycle");
	a_arm_sets: assert property (s_arm |=> run_armed)
		else $error("arm write did not arm");
	a_disarm_write: assert property (cw && !(reg_wdata[7] && reg_wdata[6]) |=> !run_armed)
		else $error("run not ended by write");
	a_secure_block: assert property (cw && mcu_secure |=> !run_armed)
		else $error("armed while secured");
	a_brk_kind: assert property (break_req |-> ctl_q[4] && !run_armed && break_tag == ctl_q[5])
		else $error("break request kind wrong");
	a_end_trig: assert property (s_end |=> !run_armed && break_req == ctl_q[4])
		else $error("end trace trigger not taken");
	a_end_hold: assert property (run_armed && !mode_q && !trg && !cw |=> run_armed)
		else $error("end trace stopped without trigger");
	a_begin_hold: assert property (run_armed && mode_q && !bus_mon.valid && !cw |=> run_armed)
		else $error("begin trace stopped on idle cycle");
endmodule
bind debug_trigger_trace_control debug_trig_asserts #(.DEPTH(DEPTH)) chk (.clk(clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .mcu_secure(mcu_secure), .begin_trace(begin_trace),
	.bus_mon(bus_mon), .break_req(break_req), .break_tag(break_tag), .run_armed(run_armed));
`default_nettype wire

// ==== tb/debug_trigger_trace_control_bench.sv ====
// Self-checking bench for the debug trigger and trace control block
`timescale 1ns/1ns
`default_nettype none
module debug_trigger_trace_control_bench import debug_trig_pkg::*; ;
	logic clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic mcu_secure = 1'h0, begin_trace = 1'h0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, ctl;
	logic break_req, break_tag, run_armed;
	bus_mon_s req = '0, bus_mon;
	logic [31:0] seed = 32'h43;
	logic [7:0] hist[$];
	int bad_count = 0, checks_done = 0, n, cnt;
	debug_trigger_trace_control #(.DEPTH(FIFO_DEPTH)) dut (.clk(clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mcu_secure(mcu_secure), .begin_trace(begin_trace),
		.bus_mon(bus_mon), .break_req(break_req), .break_tag(break_tag), .run_armed(run_armed));
	cpu_bus_model cpu (.clk(clk), .rst_b(rst_b), .req(req), .bus_mon(bus_mon));
	initial forever #10 clk = ~clk;
	// Xorshift source and expected status image
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] stat(input logic a, b, input int c);
		return {a, b, 2'h0, c[3:0]};
	endfunction
	// Comparison, register port cycles and one monitored bus cycle
	task automatic chk(input string nm, input logic [7:0] e, s);
		checks_done++;
		if (e !== s) begin
			bad_count++;
			$display("mismatch %0s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 chk("rdata", e, reg_rdata);
	endtask
	task automatic cyc(input logic [3:0] f, input logic [7:0] w);
		@(posedge clk);
		req <= {f, w};
		if (f[3]) hist.push_back(w);
		@(posedge clk);
		req <= '0;
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog against a hung run
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk);
		rd(ADDR_CONTROL, CONTROL_RESET);
		rd(ADDR_STATUS, 8'h00);
		@(posedge clk) mcu_secure <= 1'h1;
		wr(ADDR_CONTROL, 8'hC0);
		rd(ADDR_CONTROL, 8'h00);
		@(posedge clk) mcu_secure <= 1'h0;
		for (int i = 0; i < 4; i++) begin
			ctl = {2'h3, i == 2, i != 3, i[0] ? {2'h0, i[1], 1'h1} : {i[1], 1'h1, 2'h0}};
			n = rnd() % 10;
			hist.delete();
			wr(ADDR_CONTROL, ctl);
			repeat (n) cyc(4'h8, rnd());
			cyc({1'h1, ~i[1], i[0] ? 2'h1 : 2'h2}, rnd());
			cyc({1'h1, i[1], i[0] ? 2'h1 : 2'h2}, rnd());
			#1 chk("brk", {6'h0, i != 3, i == 2}, {6'h0, break_req, break_tag});
			cnt = (n + 2 > 8) ? 8 : n + 2;
			rd(ADDR_STATUS, stat(!i[0], i[0], cnt));
			rd(ADDR_CONTROL, ctl & 8'hBF);
			for (int k = cnt; k > 0; k--)
				rd(ADDR_FIFO, hist[hist.size() - k]);
			wr(ADDR_STATUS, 8'hFF);
			rd(ADDR_STATUS, stat(!i[0], i[0], cnt));
			rd(2'h3, READ_IDLE);
		end
		@(posedge clk) begin_trace <= 1'h1;
		wr(ADDR_CONTROL, 8'hF0);
		cyc(4'h8, rnd());
		rd(ADDR_STATUS, 8'h20);
		for (int k = 0; k < 8; k++)
			cyc(k ? 4'h8 : 4'hA, rnd());
		#1 chk("brk", 8'h03, {6'h0, break_req, break_tag});
		rd(ADDR_STATUS, stat(1'h1, 1'h0, 8));
		wr(ADDR_CONTROL, 8'hD0);
		cyc(4'hA, rnd());
		wr(ADDR_CONTROL, 8'h90);
		#1 chk("armed", 8'h00, {6'h0, break_req, run_armed});
		rd(ADDR_STATUS, stat(1'h1, 1'h0, 1));
		wr(ADDR_CONTROL, 8'hD0);
		wr(ADDR_CONTROL, 8'h40);
		rd(ADDR_STATUS, 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
